// [jlf_regs.svh]
`ifndef JLF_REGS_SVH
`define JLF_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// Alignment character data values (sent with the control flag set)
`define JLF_CHAR_F          8'hFC   // K28.7, frame end
`define JLF_CHAR_A          8'h7C   // K28.3, multiframe end

////////////////////////////////////////////////////////////////////////////
// Sync header patterns, bit 0 first on the line
`define JLF_SH_ONE          2'h1    // Pattern 01
`define JLF_SH_ZERO         2'h2    // Pattern 10

////////////////////////////////////////////////////////////////////////////
// Block and multiblock geometry
`define JLF_LAST_OCT_IN_BLK 3'h7
`define JLF_LAST_BLK_IN_MB  5'h1F
`define JLF_EMB_SUPPORTED   4'h1

////////////////////////////////////////////////////////////////////////////
// Sync header stream fields
`define JLF_SHS_EOEMB_POS   22
`define JLF_SHS_EOMB        5'h10   // Bits 31..27, stream order 0,0,0,0,1

////////////////////////////////////////////////////////////////////////////
// Scrambler reset values
`define JLF_SCR64_SEED      58'h0
`define JLF_SCR8_SEED       15'h0

`endif

// [jlf_pkg.sv]
package jlf_pkg;

    // Line encoding of the lane
    typedef enum logic {
        JLF_ENC_8B10B,
        JLF_ENC_64B66B
    } jlf_enc_type;

    // Parity carried in the sync header stream
    typedef enum logic {
        JLF_PAR_CRC12,
        JLF_PAR_FEC
    } jlf_parity_type;

    // Static link configuration
    typedef struct packed {
        jlf_enc_type    enc;
        jlf_parity_type parity;
        logic           scramble_enable;
        logic [8:0]     frame_octets;   // F, 1..256
        logic [8:0]     mf_frames;      // K, 1..256
        logic [3:0]     emb_count;      // E requested
    } jlf_cfg_type;

    // One lane word: an 8b/10b octet or a 66-bit block
    typedef struct packed {
        logic        is_block;
        logic        ctrl_char;
        logic        eomb;
        logic        eoemb;
        logic [7:0]  octet;
        logic [0:65] block;
    } jlf_lane_word_type;

    // Scrambler step results
    typedef struct packed {
        logic [57:0] state;
        logic [0:63] data;
    } jlf_scr64_type;

    typedef struct packed {
        logic [14:0] state;
        logic [7:0]  data;
    } jlf_scr8_type;

endpackage : jlf_pkg

// [jlf_link_framer.sv]
// Behaviour
// - Repeated unscrambled frame end octet sent as F
// - Repeated unscrambled multiframe end octet sent as A
// - Scrambled frame end 0xFC sent as F
// - Scrambled multiframe end 0x7C sent as A
// - Pack eight octets, scramble, prepend sync header
// - Header bits 0-1, octet n at 2+8n
// - Multiblock is exactly 32 blocks
// - Only one multiblock per extended multiblock
// - Extended multiblock holds whole frames
// - SYSREF phases the multiblock clock, 32 blocks
// - Header is 01 for one, 10 for zero
// - 32 headers form one stream word
// - Stream word ends 00001, unique with CRC
// - Stream bit 22 set every multiblock
// - Stream carries CRC-12 or FEC parity only
// - Scrambling forced on for 64b/66b
// - SYSREF phases the multiframe clock, K frames
module jlf_link_framer
    import jlf_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              reset_n_in,
    input  wire jlf_cfg_type       link_cfg_in,
    input  wire logic              sysref_in,
    input  wire logic [25:0]       parity_word_in,
    input  wire logic              octet_valid_in,
    input  wire logic [7:0]        octet_in,
    output logic                   octet_ready_out,
    output logic                   lane_valid_out,
    output jlf_lane_word_type      lane_word_out,
    input  wire logic              lane_ready_in,
    output logic                   lmfc_pulse_out,
    output logic                   lemc_pulse_out,
    output logic                   config_error_out
);

`include "jlf_regs.svh"

    ////////////////////////////////////////////////////////////////////////
    // Scrambler steps and sync header stream layout

    // Self-synchronous 1 + x^39 + x^58 over one block, octet 0 first
    function automatic jlf_scr64_type scr64_step(
        input logic [57:0] state,
        input logic [0:63] data
    );
        jlf_scr64_type r;
        logic          o;
        r.state = state;
        r.data  = data;
        for (int i = 0; i < 64; i++) begin
            o          = data[i] ^ r.state[38] ^ r.state[57];
            r.data[i]  = o;
            r.state    = {r.state[56:0], o};
        end
        return r;
    endfunction : scr64_step

    // Self-synchronous 1 + x^14 + x^15 over one octet, MSB first
    function automatic jlf_scr8_type scr8_step(
        input logic [14:0] state,
        input logic [7:0]  data
    );
        jlf_scr8_type r;
        logic         o;
        r.state = state;
        r.data  = data;
        for (int i = 7; i >= 0; i--) begin
            o          = data[i] ^ r.state[13] ^ r.state[14];
            r.data[i]  = o;
            r.state    = {r.state[13:0], o};
        end
        return r;
    endfunction : scr8_step

    // Stream word, bit n goes out in block n
    function automatic logic [31:0] shs_build(
        input logic [25:0] par,
        input logic        fec
    );
        logic [31:0] w;
        w = 32'h0;
        if (fec) begin
            for (int i = 0; i < 22; i++) begin
                w[i] = par[25-i];
            end
            w[23] = par[3];
            w[24] = par[2];
            w[25] = par[1];
            w[26] = par[0];
        end else begin
            w[0]  = par[11];
            w[1]  = par[10];
            w[2]  = par[9];
            w[3]  = 1'b1;
            w[4]  = par[8];
            w[5]  = par[7];
            w[6]  = par[6];
            w[7]  = 1'b1;
            w[8]  = par[5];
            w[9]  = par[4];
            w[10] = par[3];
            w[11] = 1'b1;
            w[12] = par[2];
            w[13] = par[1];
            w[14] = par[0];
            w[15] = 1'b1;
            w[19] = 1'b1;   // Command bits stay zero
            w[21] = 1'b1;
            w[23] = 1'b1;
        end
        w[`JLF_SHS_EOEMB_POS] = 1'b1;
        w[31:27] = `JLF_SHS_EOMB;
        return w;
    endfunction : shs_build

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic              sysref_meta_reg;
    logic              sysref_sync_reg;
    logic              sysref_prev_reg;
    logic [8:0]        oct_pos_reg;
    logic [8:0]        frm_pos_reg;
    logic [2:0]        blk_oct_reg;
    logic [4:0]        blk_idx_reg;
    logic [7:0]        prev_last_reg;
    logic [0:55]       blk_acc_reg;
    logic [57:0]       scr64_reg;
    logic [14:0]       scr8_reg;
    logic [25:0]       parity_hold_reg;
    logic              cfg_err_reg;
    logic              in_ready_reg;
    logic              lane_valid_reg;
    jlf_lane_word_type lane_word_reg;
    logic              spare_valid_reg;
    jlf_lane_word_type spare_word_reg;
    logic              lmfc_pulse_reg;
    logic              lemc_pulse_reg;

    logic              sysref_edge;
    logic              mode64;
    logic              fire;
    logic              push;
    logic [8:0]        oct_base;
    logic [8:0]        frm_base;
    logic [2:0]        blko_base;
    logic [4:0]        blk_base;
    logic              frame_last;
    logic              mf_last;
    logic              blk_full;
    logic              mb_last;
    logic [8:0]        oct_pos_next;
    logic [8:0]        frm_pos_next;
    logic [2:0]        blk_oct_next;
    logic [4:0]        blk_idx_next;
    jlf_scr8_type      scr8_res;
    logic [7:0]        oct8;
    logic              repeat_oct;
    logic              use_a;
    logic              use_f;
    logic [7:0]        char_oct;
    jlf_scr64_type     scr64_res;
    logic [25:0]       parity_use;
    logic [31:0]       shs_word;
    logic [0:65]       block_word;
    jlf_lane_word_type in_word;
    logic              cfg_err_next;
    logic              pop;
    logic              head_take_in;
    logic              head_take_spare;
    logic              spare_take_in;
    logic              lane_valid_next;
    logic              spare_valid_next;

    ////////////////////////////////////////////////////////////////////////
    // SYSREF capture, two stages before the edge detector

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sysref_meta_reg <= 1'b0;
            sysref_sync_reg <= 1'b0;
            sysref_prev_reg <= 1'b0;
        end else begin
            sysref_meta_reg <= sysref_in;
            sysref_sync_reg <= sysref_meta_reg;
            sysref_prev_reg <= sysref_sync_reg;
        end
    end

    // Rising SYSREF restarts every frame and block counter
    assign sysref_edge = sysref_sync_reg & ~sysref_prev_reg;
    assign oct_base    = sysref_edge ? 9'h000 : oct_pos_reg;
    assign frm_base    = sysref_edge ? 9'h000 : frm_pos_reg;
    assign blko_base   = sysref_edge ? 3'h0 : blk_oct_reg;
    assign blk_base    = sysref_edge ? 5'h00 : blk_idx_reg;

    ////////////////////////////////////////////////////////////////////////
    // Position decode

    assign mode64     = (link_cfg_in.enc == JLF_ENC_64B66B);
    assign fire       = octet_valid_in & in_ready_reg;
    assign frame_last = (oct_base == link_cfg_in.frame_octets - 9'h001);
    assign mf_last    = frame_last &
                        (frm_base == link_cfg_in.mf_frames - 9'h001);
    assign blk_full   = (blko_base == `JLF_LAST_OCT_IN_BLK);
    assign mb_last    = blk_full & (blk_base == `JLF_LAST_BLK_IN_MB);

    // Counter advance on each accepted octet
    assign oct_pos_next = !fire ? oct_base :
                          frame_last ? 9'h000 : oct_base + 9'h001;
    assign frm_pos_next = !(fire & frame_last) ? frm_base :
                          mf_last ? 9'h000 : frm_base + 9'h001;
    assign blk_oct_next = fire ? blko_base + 3'h1 : blko_base;
    assign blk_idx_next = (fire & blk_full) ? blk_base + 5'h01
                                            : blk_base;

    ////////////////////////////////////////////////////////////////////////
    // 8b/10b alignment character substitution

    assign scr8_res   = scr8_step(scr8_reg, octet_in);
    assign oct8       = link_cfg_in.scramble_enable ? scr8_res.data
                                                    : octet_in;
    assign repeat_oct = (oct8 == prev_last_reg);

    // A wins at a multiframe end, else F at a frame end
    assign use_a = mf_last & (link_cfg_in.scramble_enable ?
                   (oct8 == `JLF_CHAR_A) : repeat_oct);
    assign use_f = frame_last & ~use_a & (link_cfg_in.scramble_enable ?
                   (oct8 == `JLF_CHAR_F) : repeat_oct);
    assign char_oct = use_a ? `JLF_CHAR_A :
                      use_f ? `JLF_CHAR_F : oct8;

    ////////////////////////////////////////////////////////////////////////
    // 64b/66b block assembly

    assign scr64_res  = scr64_step(scr64_reg, {blk_acc_reg, octet_in});
    assign parity_use = (blk_base == 5'h00) ? parity_word_in
                                            : parity_hold_reg;
    assign shs_word   = shs_build(parity_use,
                                  link_cfg_in.parity == JLF_PAR_FEC);
    assign block_word = {shs_word[blk_base] ? `JLF_SH_ONE
                                            : `JLF_SH_ZERO,
                         scr64_res.data};

    // Word handed to the buffer
    assign push              = fire & (~mode64 | blk_full);
    assign in_word.is_block  = mode64;
    assign in_word.ctrl_char = ~mode64 & (use_a | use_f);
    assign in_word.eomb      = mode64 & mb_last;
    assign in_word.eoemb     = mode64 & mb_last;
    assign in_word.octet     = mode64 ? 8'h00 : char_oct;
    assign in_word.block     = mode64 ? block_word : 66'h0;

    // Unsupported E or a frame split across the multiblock end
    assign cfg_err_next = cfg_err_reg |
        (mode64 & (link_cfg_in.emb_count != `JLF_EMB_SUPPORTED)) |
        (mode64 & push & mb_last & ~frame_last);

    ////////////////////////////////////////////////////////////////////////
    // Framing state

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            oct_pos_reg <= 9'h000;
            frm_pos_reg <= 9'h000;
            blk_oct_reg <= 3'h0;
            blk_idx_reg <= 5'h00;
            cfg_err_reg <= 1'b0;
        end else begin
            oct_pos_reg <= oct_pos_next;
            frm_pos_reg <= frm_pos_next;
            blk_oct_reg <= blk_oct_next;
            blk_idx_reg <= blk_idx_next;
            cfg_err_reg <= cfg_err_next;
        end
    end

    // Data history and scrambler states
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev_last_reg   <= 8'h00;
            blk_acc_reg     <= 56'h0;
            scr64_reg       <= `JLF_SCR64_SEED;
            scr8_reg        <= `JLF_SCR8_SEED;
            parity_hold_reg <= 26'h0;
        end else begin
            if (fire & frame_last)
                prev_last_reg <= oct8;
            if (fire)
                blk_acc_reg <= {blk_acc_reg[8:55], octet_in};
            if (push & mode64)
                scr64_reg <= scr64_res.state;
            if (fire & ~mode64 & link_cfg_in.scramble_enable)
                scr8_reg <= scr8_res.state;
            if (push & mode64 & (blk_base == 5'h00))
                parity_hold_reg <= parity_word_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry output buffer, head register drives the lane

    assign pop              = lane_valid_reg & lane_ready_in;
    assign head_take_in     = push & (~lane_valid_reg | pop);
    assign spare_take_in    = push & lane_valid_reg & ~pop;
    assign head_take_spare  = pop & spare_valid_reg;
    assign lane_valid_next  = head_take_in | head_take_spare |
                              (lane_valid_reg & ~pop);
    assign spare_valid_next = spare_take_in | (spare_valid_reg & ~pop);

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lane_valid_reg  <= 1'b0;
            lane_word_reg   <= '0;
            spare_valid_reg <= 1'b0;
            spare_word_reg  <= '0;
            in_ready_reg    <= 1'b0;
        end else begin
            lane_valid_reg  <= lane_valid_next;
            spare_valid_reg <= spare_valid_next;
            in_ready_reg    <= ~spare_valid_next & ~cfg_err_next;
            if (head_take_in)
                lane_word_reg <= in_word;
            else if (head_take_spare)
                lane_word_reg <= spare_word_reg;
            if (spare_take_in)
                spare_word_reg <= in_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiframe and multiblock end pulses

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lmfc_pulse_reg <= 1'b0;
            lemc_pulse_reg <= 1'b0;
        end else begin
            lmfc_pulse_reg <= fire & ~mode64 & mf_last;
            lemc_pulse_reg <= push & mode64 & mb_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign octet_ready_out  = in_ready_reg;
    assign lane_valid_out   = lane_valid_reg;
    assign lane_word_out    = lane_word_reg;
    assign lmfc_pulse_out   = lmfc_pulse_reg;
    assign lemc_pulse_out   = lemc_pulse_reg;
    assign config_error_out = cfg_err_reg;

endmodule : jlf_link_framer

// [jlf_link_framer_checker.sv]
`include "jlf_regs.svh"
module jlf_link_framer_checker
    import jlf_pkg::*;
(
    input wire logic              clk_sys_in,
    input wire logic              reset_n_in,
    input wire jlf_cfg_type       link_cfg_in,
    input wire logic              sysref_in,
    input wire logic [25:0]       parity_word_in,
    input wire logic              octet_valid_in,
    input wire logic [7:0]        octet_in,
    input wire logic              octet_ready_out,
    input wire logic              lane_valid_out,
    input wire jlf_lane_word_type lane_word_out,
    input wire logic              lane_ready_in,
    input wire logic              lmfc_pulse_out,
    input wire logic              lemc_pulse_out,
    input wire logic              config_error_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]        blk_cnt_reg;
    logic [3:0]        hist_reg;
    logic              take_blk;
    jlf_lane_word_type lw;

    ////////////////////////////////////////////////////////////////////////
    // Blocks taken by the sink and their last header bits
    assign lw = lane_word_out;
    assign take_blk = lane_valid_out && lane_ready_in && lw.is_block;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            blk_cnt_reg <= 5'h00;
            hist_reg    <= 4'h0;
        end else if (take_blk) begin
            blk_cnt_reg <= blk_cnt_reg + 5'h01;
            hist_reg    <= {hist_reg[2:0], lw.block[1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Properties on the design's outputs
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    a_word_held: assert property (lane_valid_out && !lane_ready_in |=>
        lane_valid_out && $stable(lane_word_out))
        else $error("lane word changed before it was taken");
    a_mb_length: assert property (take_blk |->
        lw.eomb == (blk_cnt_reg == 5'h1F))
        else $error("multiblock end not on block 31");
    a_hdr_pair: assert property (lane_valid_out && lw.is_block |->
        lw.block[0] != lw.block[1])
        else $error("sync header bits not complementary");
    a_eomb_tail: assert property (take_blk && lw.eomb |->
        hist_reg == 4'h0 && lw.block[0:1] == `JLF_SH_ONE)
        else $error("stream word does not end in 00001");
    a_emb_one: assert property (lane_valid_out && lw.is_block |->
        lw.eoemb == lw.eomb)
        else $error("extended multiblock end differs from multiblock end");
    a_ctrl_code: assert property (lane_valid_out && lw.ctrl_char |->
        lw.octet == `JLF_CHAR_F || lw.octet == `JLF_CHAR_A)
        else $error("control character is neither F nor A");
    a_err_stops: assert property (config_error_out |->
        !octet_ready_out) else $error("octets accepted during config error");
    a_err_sticky: assert property (config_error_out |=>
        config_error_out) else $error("config error cleared without reset");
    a_emb_reject: assert property (link_cfg_in.enc == JLF_ENC_64B66B &&
        link_cfg_in.emb_count != 4'h1 |-> ##[0:4] config_error_out)
        else $error("unsupported multiblock count accepted");
    a_lemc_pulse: assert property (lemc_pulse_out |=>
        !lemc_pulse_out) else $error("multiblock pulse too long");
    a_lmfc_mode: assert property (lmfc_pulse_out |->
        link_cfg_in.enc == JLF_ENC_8B10B)
        else $error("multiframe pulse outside octet mode");
endmodule : jlf_link_framer_checker

// [jlf_rx_model.sv]
`include "jlf_regs.svh"
module jlf_rx_model
    import jlf_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire jlf_cfg_type       cfg_in,
    input  wire logic              slow_in,
    input  wire logic              lane_valid_in,
    input  wire jlf_lane_word_type lane_word_in,
    output logic                   lane_ready_out,
    output logic                   got_out,
    output jlf_lane_word_type      got_word_out,
    output logic [7:0]             got_octet_out,
    output logic                   misalign_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pace_reg;
    logic [8:0] pos_reg, frm_reg;
    logic [7:0] prev_reg, data_next;
    logic       take, frame_end, mf_end, bad_pos, bad_hdr;

    ////////////////////////////////////////////////////////////////////////
    // Frame position and restoring of alignment characters
    assign take = lane_valid_in && lane_ready_out;
    assign frame_end = pos_reg == cfg_in.frame_octets - 9'h001;
    assign mf_end = frame_end && frm_reg == cfg_in.mf_frames - 9'h001;
    assign data_next = !lane_word_in.ctrl_char ? lane_word_in.octet
        : cfg_in.scramble_enable ? lane_word_in.octet
        : prev_reg;
    assign bad_pos = lane_word_in.ctrl_char && (!frame_end ||
        (lane_word_in.octet == `JLF_CHAR_A && !mf_end));
    assign bad_hdr = lane_word_in.block[0] == lane_word_in.block[1];

    // Sink with prompt or slow acceptance, sticky error flag
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pace_reg       <= 2'h0;
            pos_reg        <= 9'h000;
            frm_reg        <= 9'h000;
            prev_reg       <= 8'h00;
            lane_ready_out <= 1'b0;
            got_out        <= 1'b0;
            got_word_out   <= '0;
            got_octet_out  <= 8'h00;
            misalign_out   <= 1'b0;
        end else begin
            pace_reg       <= pace_reg + 2'h1;
            lane_ready_out <= !slow_in || pace_reg == 2'h3;
            got_out        <= take;
            if (take) begin
                got_word_out  <= lane_word_in;
                got_octet_out <= data_next;
                if (lane_word_in.is_block)
                    misalign_out <= misalign_out | bad_hdr;
                else begin
                    misalign_out <= misalign_out | bad_pos;
                    pos_reg <= frame_end ? 9'h000 : pos_reg + 9'h001;
                    if (frame_end) begin
                        prev_reg <= data_next;
                        frm_reg  <= mf_end ? 9'h000 : frm_reg + 9'h001;
                    end
                end
            end
        end
    end
endmodule : jlf_rx_model

// [jlf_link_framer_test.sv]
`include "jlf_regs.svh"
module jlf_link_framer_test;
    import jlf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] din, dout;
        logic       ctrl;
    } jlf_row_type;
    localparam logic [25:0] PAR = 26'h2A5C3E1;
    logic clk, rst_n, sref, ov, ordy, lv, lr, lmfc, lemc, cerr, slow, got, mis;
    logic [7:0]        oc, go;
    logic [31:0]       s;
    jlf_cfg_type       cfg;
    jlf_lane_word_type lw, gw;
    jlf_lane_word_type rx_q[$];
    logic [7:0]        ro_q[$];
    int n_mismatch = 0, num_checks = 0, n_lmfc = 0, n_lemc = 0;
    // Frame 2 octets, multiframe 2 frames
    jlf_row_type rows [12] = '{
        '{8'h11, 8'h11, 1'b0}, '{8'h22, 8'h22, 1'b0},
        '{8'h33, 8'h33, 1'b0}, '{8'h22, `JLF_CHAR_A, 1'b1},
        '{8'h44, 8'h44, 1'b0}, '{8'h22, `JLF_CHAR_F, 1'b1},
        '{8'h55, 8'h55, 1'b0}, '{8'h66, 8'h66, 1'b0},
        '{8'h77, 8'h77, 1'b0}, '{8'h66, `JLF_CHAR_F, 1'b1},
        '{8'h88, 8'h88, 1'b0}, '{8'h66, `JLF_CHAR_A, 1'b1}};

    ////////////////////////////////////////////////////////////////////////
    // Design, far-side receiver, clock and capture
    jlf_link_framer u_jlf_link_framer (
        .clk_sys_in(clk), .reset_n_in(rst_n), .link_cfg_in(cfg),
        .sysref_in(sref), .parity_word_in(PAR), .octet_valid_in(ov),
        .octet_in(oc), .octet_ready_out(ordy), .lane_valid_out(lv),
        .lane_word_out(lw), .lane_ready_in(lr), .lmfc_pulse_out(lmfc),
        .lemc_pulse_out(lemc), .config_error_out(cerr));
    jlf_rx_model u_jlf_rx_model (
        .clk_in(clk), .reset_n_in(rst_n), .cfg_in(cfg), .slow_in(slow),
        .lane_valid_in(lv), .lane_word_in(lw), .lane_ready_out(lr),
        .got_out(got), .got_word_out(gw), .got_octet_out(go),
        .misalign_out(mis));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (got) begin
            rx_q.push_back(gw);
            ro_q.push_back(go);
        end
        if (lmfc) n_lmfc++;
        if (lemc) n_lemc++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // Reset for 6 cycles with a new config, then one SYSREF pulse
    task automatic restart(input jlf_cfg_type c);
        @(posedge clk);
        rst_n <= 1'b0;
        cfg   <= c;
        rx_q.delete();
        ro_q.delete();
        repeat (6) @(posedge clk);
        {n_lmfc, n_lemc} = 64'h0;
        rst_n <= 1'b1;
        sref  <= 1'b1;
        repeat (4) @(posedge clk);
        sref  <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : restart
    // Offer one octet and hold it until taken
    task automatic send(input logic [7:0] v);
        int n = 0;
        ov <= 1'b1;
        oc <= v;
        @(negedge clk);
        while (ordy !== 1'b1 && cerr !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask : send
    task automatic wait_rx(input int n);
        int k = 0;
        ov <= 1'b0;
        while (rx_q.size() < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        @(negedge clk);
    endtask : wait_rx
    // Stream word expected for CRC-12 or FEC layout
    function automatic logic [31:0] exp_stream(input logic fec,
                                               input logic [25:0] p);
        logic [31:0] r;
        r = fec ? 32'h8000_0000 : 32'h80A8_0000;
        for (int n = 0; n < 27; n++) begin
            if (fec) r[n] = p[n < 22 ? 25 - n : 26 - n];
            else if (n < 16) r[n] = (n % 4 == 3) ? 1'b1 : p[11 - n + n / 4];
        end
        r[22] = 1'b1;
        return r;
    endfunction : exp_stream

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 1'b0; rst_n = 1'b0; sref = 1'b0; ov = 1'b0; oc = 8'h00;
        slow = 1'b1;
        restart('{JLF_ENC_8B10B, JLF_PAR_CRC12, 1'b0, 9'h002, 9'h002, 4'h1});
        foreach (rows[i]) send(rows[i].din);
        wait_rx(12);
        check(rx_q.size(), 12);
        foreach (rows[i]) begin
            check(rx_q[i].octet, rows[i].dout);
            check(rx_q[i].ctrl_char, rows[i].ctrl);
            check(ro_q[i], rows[i].din);
        end
        check(n_lmfc, 3);
        check(mis, 1'b0);
        restart('{JLF_ENC_8B10B, JLF_PAR_CRC12, 1'b1, 9'h001, 9'h002, 4'h1});
        send(`JLF_CHAR_F); // Unscrambled, state still zero
        send(8'h7E); // Scrambles to 0x7C behind a leading 0xFC
        wait_rx(2);
        check({rx_q[0].ctrl_char, rx_q[1].ctrl_char}, 2'h3);
        check({rx_q[0].octet, rx_q[1].octet}, 16'hFC7C);
        check({ro_q[0], ro_q[1]}, 16'hFC7C);
        for (int p = 0; p < 2; p++) begin
            slow <= p[0];
            restart('{JLF_ENC_64B66B, jlf_parity_type'(p[0]), 1'b0,
                      9'h002, 9'h002, 4'h1});
            for (int i = 0; i < 256; i++) send(i[7:0]);
            wait_rx(32);
            check(rx_q.size(), 32);
            for (int b = 0; b < 32; b++) begin
                s[b] = rx_q[b].block[1];
                check(rx_q[b].eomb, b == 31);
            end
            check(s, exp_stream(p[0], PAR));
            check(n_lemc, 1);
            check(mis, 1'b0);
        end
        // Unsupported extended multiblock, then a mid-frame multiblock end
        restart('{JLF_ENC_64B66B, JLF_PAR_CRC12, 1'b1, 9'h002, 9'h002, 4'h2});
        @(negedge clk);
        check(cerr, 1'b1);
        check(ordy, 1'b0);
        restart('{JLF_ENC_64B66B, JLF_PAR_FEC, 1'b1, 9'h003, 9'h002, 4'h1});
        for (int i = 0; i < 256; i++) send(8'h5A);
        wait_rx(0);
        check(cerr, 1'b1);
        check(ordy, 1'b0);
        end_of_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        n_mismatch++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule : jlf_link_framer_test

bind jlf_link_framer jlf_link_framer_checker u_jlf_link_framer_checker (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .link_cfg_in(link_cfg_in), .sysref_in(sysref_in),
    .parity_word_in(parity_word_in), .octet_valid_in(octet_valid_in),
    .octet_in(octet_in), .octet_ready_out(octet_ready_out),
    .lane_valid_out(lane_valid_out), .lane_word_out(lane_word_out),
    .lane_ready_in(lane_ready_in), .lmfc_pulse_out(lmfc_pulse_out),
    .lemc_pulse_out(lemc_pulse_out), .config_error_out(config_error_out));
